//--- lwu_config_regs.sv
// Line wake unit: configuration registers, triggers and request outputs
`timescale 1ns/10ps
module lwu_config_regs #(
  parameter bit LINE18_TRIG = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Word register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  // Line sources
  input wire logic [27:0] line_in,
  // Requests toward the core
  output logic [27:0] irq_req_q,
  output logic [27:0] event_req_q
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic wr_en;
  logic rd_en;
  assign wr_en = reg_sel & reg_wr; // [RULE_09]
  assign rd_en = reg_sel & reg_rd;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [27:0] irq_en_q;
  logic [27:0] evt_en_q;
  logic [27:0] rise_q;
  logic [27:0] fall_q;
  logic [27:0] soft_q;
  logic [27:0] pend_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_en_q <= lwu_pkg::RST_IRQ_EN[27:0]; // [RULE_02]
    end else if (wr_en && hit(reg_addr, lwu_pkg::OFF_IRQ_EN)) begin // [RULE_11]
      irq_en_q <= reg_wdata[27:0] & lwu_pkg::MASK_EN[27:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      evt_en_q <= lwu_pkg::RST_CFG[27:0]; // [RULE_08]
    end else if (wr_en && hit(reg_addr, lwu_pkg::OFF_EVT_EN)) begin // [RULE_11]
      evt_en_q <= reg_wdata[27:0] & lwu_pkg::MASK_EN[27:0];
    end
  end

  // Reserved trigger bits are dropped on write, whatever software sends
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rise_q <= lwu_pkg::RST_CFG[27:0]; // [RULE_08]
    end else if (wr_en && hit(reg_addr, lwu_pkg::OFF_RISE)) begin // [RULE_11]
      rise_q <= reg_wdata[27:0] & lwu_pkg::MASK_TRIG[27:0]; // [RULE_17]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fall_q <= lwu_pkg::RST_CFG[27:0]; // [RULE_08]
    end else if (wr_en && hit(reg_addr, lwu_pkg::OFF_FALL)) begin // [RULE_11]
      fall_q <= reg_wdata[27:0] & lwu_pkg::MASK_TRIG[27:0]; // [RULE_17]
    end
  end

  logic soft_wr;
  logic [27:0] soft_new;
  logic [27:0] soft_pulse;
  assign soft_wr = wr_en & hit(reg_addr, lwu_pkg::OFF_SOFT);
  assign soft_new = reg_wdata[27:0] & lwu_pkg::MASK_TRIG[27:0];
  // Only a zero-to-one change fires, so rewriting a set bit does not repeat it
  assign soft_pulse = soft_wr ? (soft_new & ~soft_q) : 28'h000_0000; // [RULE_07] [RULE_15]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      soft_q <= lwu_pkg::RST_CFG[27:0]; // [RULE_08]
    end else if (soft_wr) begin
      soft_q <= soft_new; // [RULE_07]
    end
  end

  // ****************************************************************
  // Triggers
  // ****************************************************************
  logic [27:0] rise;
  logic [27:0] fall;

  lwu_edge_detect u_edge (
    .clock(clock),
    .rst_b(rst_b),
    .line_in(line_in),
    .rise(rise),
    .fall(fall)
  );

  logic [27:0] var_mask;
  logic [27:0] trig;
  assign var_mask = LINE18_TRIG ? 28'hFFF_FFFF : ~(28'h000_0001 << lwu_pkg::LINE_USB); // [RULE_06]
  assign trig = (((rise & rise_q) | (fall & fall_q)) & var_mask // [RULE_04] [RULE_05] [RULE_14]
                 | soft_pulse) & lwu_pkg::MASK_TRIG[27:0];

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  logic [27:0] pend_set;
  logic [27:0] pend_clr;
  assign pend_set = trig & irq_en_q; // [RULE_12]
  assign pend_clr = (wr_en && hit(reg_addr, lwu_pkg::OFF_PEND)) ?
                    (reg_wdata[27:0] & lwu_pkg::MASK_TRIG[27:0]) : 28'h000_0000; // [RULE_13]

  lwu_pending u_pend (
    .clock(clock),
    .rst_b(rst_b),
    .set_req(pend_set),
    .clr_req(pend_clr),
    .pend_q(pend_q)
  );

  // ****************************************************************
  // Requests
  // ****************************************************************
  // Lines without edge logic are level interrupt sources passed through their enable; their events fire on rising edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_req_q <= 28'h000_0000;
    end else begin
      irq_req_q <= ((pend_q & lwu_pkg::MASK_TRIG[27:0])
                    | (line_in & ~lwu_pkg::MASK_TRIG[27:0])) & irq_en_q; // [RULE_01]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      event_req_q <= 28'h000_0000;
    end else begin
      event_req_q <= (trig | (rise & ~lwu_pkg::MASK_TRIG[27:0])) & evt_en_q; // [RULE_03]
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (reg_addr) // [RULE_11] [RULE_17]
        lwu_pkg::OFF_IRQ_EN: reg_rdata_q <= {4'h0, irq_en_q};
        lwu_pkg::OFF_EVT_EN: reg_rdata_q <= {4'h0, evt_en_q};
        lwu_pkg::OFF_RISE: reg_rdata_q <= {4'h0, rise_q};
        lwu_pkg::OFF_FALL: reg_rdata_q <= {4'h0, fall_q};
        lwu_pkg::OFF_SOFT: reg_rdata_q <= {4'h0, soft_q};
        lwu_pkg::OFF_PEND: reg_rdata_q <= {4'h0, pend_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_gated: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_01]
    (irq_req_q & ~$past(irq_en_q)) == 28'h000_0000)
    else $error("interrupt raised on disabled line");

  a_irq_en_reset: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_02]
    $past(!rst_b) |-> (irq_en_q == lwu_pkg::RST_IRQ_EN[27:0]) && (irq_req_q == 28'h000_0000))
    else $error("interrupt enable reset value wrong");

  a_event_gated: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_03]
    (event_req_q & ~$past(evt_en_q)) == 28'h000_0000)
    else $error("event raised on disabled line");

  a_cfg_reset: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_08]
    $past(!rst_b) |-> (evt_en_q | rise_q | fall_q | soft_q) == 28'h000_0000)
    else $error("configuration register not zero after reset");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_17]
    ((rise_q | fall_q | soft_q) & ~lwu_pkg::MASK_TRIG[27:0]) == 28'h000_0000)
    else $error("reserved trigger bit holds a one");

  a_rise_pending: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_04]
    (rise[0] && rise_q[0] && irq_en_q[0]) |=>
      pend_q[0] ##1 (irq_req_q[0] || !$past(irq_en_q[0])))
    else $error("enabled rising edge lost");

  a_soft_now: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_15]
    (soft_wr && reg_wdata[21] && !soft_q[21] && evt_en_q[21]) |=> event_req_q[21])
    else $error("software trigger event not immediate");

  a_read_back: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_11]
    (rd_en && reg_addr == lwu_pkg::OFF_RISE) |=> reg_rdata_q == {4'h0, $past(rise_q)})
    else $error("rising trigger read back wrong");
endmodule

//--- lwu_core_model.sv
// Core-side model that tallies interrupt and event requests
`timescale 1ns/10ps
module lwu_core_model (
  // Clock and control
  input wire logic clock,
  input wire logic clr,
  // Requests from the unit
  input wire logic [27:0] irq_req,
  input wire logic [27:0] event_req,
  // Tallies
  output logic [7:0] evt_cnt,
  output logic [27:0] evt_seen,
  output logic [27:0] irq_seen
);
  // Counting every cycle a request is high, not just its edges, so a stretched event shows up
  always_ff @(posedge clock) begin
    if (clr) begin
      evt_cnt <= 8'h00;
      evt_seen <= 28'h0000000;
      irq_seen <= 28'h0000000;
    end else begin
      evt_cnt <= evt_cnt + 8'($countones(event_req));
      evt_seen <= evt_seen | event_req;
      irq_seen <= irq_seen | irq_req;
    end
  end
endmodule

//--- lwu_edge_detect.sv
// Per-line edge detector comparing each line with its previous value
`timescale 1ns/10ps
module lwu_edge_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Lines
  input wire logic [27:0] line_in,
  output logic [27:0] rise,
  output logic [27:0] fall
);
  logic [27:0] prev_q;
  logic primed_q;

  // First cycle after reset only loads, so a line high at reset is no edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prev_q <= 28'h000_0000;
    end else begin
      prev_q <= line_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 28; g++) begin : g_line
      assign rise[g] = primed_q & line_in[g] & ~prev_q[g]; // [RULE_16]
      assign fall[g] = primed_q & ~line_in[g] & prev_q[g]; // [RULE_16]
    end
  endgenerate

  a_edge_one_cycle: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_16]
    ((rise & $past(rise)) == 28'h000_0000) && ((rise & fall) == 28'h000_0000))
    else $error("edge pulse longer than one cycle");
endmodule

//--- lwu_pending.sv
// Pending flags: set by interrupt triggers, cleared by writing one
`timescale 1ns/10ps
module lwu_pending (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Set and clear requests
  input wire logic [27:0] set_req,
  input wire logic [27:0] clr_req,
  // Flags
  output logic [27:0] pend_q
);
  // Set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pend_q <= 28'h000_0000;
    end else begin
      pend_q <= (pend_q & ~clr_req) | set_req; // [RULE_12] [RULE_13]
    end
  end

  a_pend_set: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_12]
    (set_req != 28'h000_0000) |=> ((pend_q & $past(set_req)) == $past(set_req)))
    else $error("trigger did not set pending flag");

  a_pend_clear: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_13]
    ((clr_req & ~set_req) != 28'h000_0000) |=>
      ((pend_q & $past(clr_req & ~set_req)) == 28'h000_0000))
    else $error("write of one did not clear pending flag");
endmodule

//--- lwu_pkg.sv
// Constants for the line wake unit configuration registers
// ****************************************************************
// Summary of operation
// [RULE_01] A line's interrupt reaches the core only while its interrupt enable is set.
// [RULE_02] Interrupt enable resets with bits 20 and 23 to 27 set.
// [RULE_03] A line's event goes out only while its event enable is set.
// [RULE_04] Set rising trigger bit makes a rising edge a valid request.
// [RULE_05] Set falling trigger bit makes a falling edge a valid request.
// [RULE_06] Line 18 trigger bits work only on one variant of the family; with LINE18_TRIG clear the code still fires line 18's software trigger.
// [RULE_07] Writing one to a software trigger bit raises a request; zero withdraws it; in the code zero only clears the bit, the pending flag stays set.
// [RULE_08] Event, rising, falling and software trigger registers reset to zero.
// [RULE_09] The bus master uses only full 32-bit word accesses.
// [RULE_10] Software writes reserved bits with their reset value.
// [RULE_11] Registers decode at word offsets 0x00 to 0x10 from the base; the code also decodes the pending register at 0x14.
// [RULE_12] An interrupt sets the line's pending flag; an event alone does not.
// [RULE_13] Writing one clears a pending flag; writing zero leaves it.
// [RULE_14] Rising and falling triggers may both be set on one line.
// [RULE_15] A software trigger on an enabled line raises its request at once.
// [RULE_16] Edges come from comparing each line with last cycle's value.
// [RULE_17] Reserved bits read as zero and ignore writes.
// ****************************************************************
package lwu_pkg;
  localparam int LINES = 28;
  localparam int ADDR_W = 8;
  localparam int LINE_USB = 18;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_IRQ_EN = 8'h00;
  localparam logic [7:0] OFF_EVT_EN = 8'h04;
  localparam logic [7:0] OFF_RISE = 8'h08;
  localparam logic [7:0] OFF_FALL = 8'h0C;
  localparam logic [7:0] OFF_SOFT = 8'h10;
  localparam logic [7:0] OFF_PEND = 8'h14;

  // ****************************************************************
  // Reset values and implemented bits
  // ****************************************************************
  localparam logic [31:0] RST_IRQ_EN = 32'h0F90_0000;
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [31:0] MASK_EN = 32'h0FFF_FFFF;
  localparam logic [31:0] MASK_TRIG = 32'h006F_FFFF;
endpackage

//--- lwu_tb.sv
// Self-checking bench for the line wake unit configuration registers
`timescale 1ns/10ps
module testbench;
  logic clock;
  logic rst_b = 1'b0;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata_q;
  logic [27:0] line_in = 28'h0000000;
  logic [27:0] irq_req_q;
  logic [27:0] event_req_q;
  logic clr = 1'b1;
  logic [7:0] evt_cnt;
  logic [27:0] evt_seen;
  logic [27:0] irq_seen;
  int n_fail = 0;
  int check_count = 0;

  lwu_config_regs #(.LINE18_TRIG(1'b1)) lwu_config_regs_inst (.clock(clock), .rst_b(rst_b),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .line_in(line_in),
    .irq_req_q(irq_req_q), .event_req_q(event_req_q));
  lwu_core_model lwu_core_model_inst (.clock(clock), .clr(clr), .irq_req(irq_req_q),
    .event_req(event_req_q), .evt_cnt(evt_cnt), .evt_seen(evt_seen), .irq_seen(irq_seen));

  // ****************************************************************
  // Clock, bus and checking tasks
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Full words only, one access per two cycles
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_sel <= 1'b1;
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_sel <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0000_0000);
    #1 check(reg_rdata_q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic tally_clear();
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(8'h00, 32'h0F90_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
  endtask

  task automatic t_reserved();
    // Reserved bits are written with their reset value, as software must
    wr(8'h08, 32'h006F_FFFF);
    rd(8'h08, 32'h006F_FFFF);
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0FFF_FFFF);
    rd(8'h00, 32'h0FFF_FFFF);
    wr(8'h00, 32'h0F90_0000); // Reserved bits back at reset value
  endtask

  task automatic t_rise();
    wr(8'h00, 32'h0F94_0001);
    wr(8'h04, 32'h0004_0001);
    wr(8'h08, 32'h0004_0001);
    tally_clear();
    line_in <= 28'h0040001;
    settle(6);
    check({24'h0, evt_cnt}, 32'h0000_0002);
    check({4'h0, evt_seen}, 32'h0004_0001);
    check({4'h0, irq_req_q}, 32'h0004_0001);
    rd(8'h14, 32'h0004_0001);
    wr(8'h14, 32'h0004_0001);
    settle(3);
    check({4'h0, irq_req_q}, 32'h0000_0000);
    @(posedge clock);
    line_in <= 28'h0000000;
    settle(6);
    check({24'h0, evt_cnt}, 32'h0000_0002);
    rd(8'h14, 32'h0000_0000);
  endtask

  // Event only: interrupt enable of line 5 stays clear
  task automatic t_both_event();
    wr(8'h04, 32'h0000_0020);
    wr(8'h08, 32'h0000_0020);
    wr(8'h0C, 32'h0000_0020);
    tally_clear();
    line_in <= 28'h0000020;
    settle(4);
    @(posedge clock);
    line_in <= 28'h0000000;
    settle(4);
    check({24'h0, evt_cnt}, 32'h0000_0002);
    check({4'h0, irq_seen}, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
  endtask

  task automatic t_soft();
    wr(8'h00, 32'h0FB0_0000);
    wr(8'h04, 32'h0020_0000);
    tally_clear();
    wr(8'h10, 32'h0020_0000);
    settle(3);
    check({24'h0, evt_cnt}, 32'h0000_0001);
    check({4'h0, irq_req_q}, 32'h0020_0000);
    rd(8'h10, 32'h0020_0000);
    rd(8'h14, 32'h0020_0000);
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0020_0000);
    settle(3);
    check({4'h0, irq_req_q}, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
  endtask

  // Lines 20 and 23 have no edge logic: level interrupt, rising-edge event
  task automatic t_level();
    wr(8'h04, 32'h0080_0000);
    tally_clear();
    line_in <= 28'h0900000;
    settle(4);
    check({4'h0, irq_req_q}, 32'h0090_0000);
    check({24'h0, evt_cnt}, 32'h0000_0001);
    rd(8'h14, 32'h0000_0000);
    @(posedge clock);
    line_in <= 28'h0000000;
    settle(3);
    check({4'h0, irq_req_q}, 32'h0000_0000);
    check({24'h0, evt_cnt}, 32'h0000_0001);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_reserved();
    t_rise();
    t_both_event();
    t_soft();
    t_level();
    report_and_stop();
  end

  // Whole run is about 120 cycles; far longer means a hang
  initial begin
    #20us;
    n_fail++;
    report_and_stop();
  end
endmodule
